// ---- pio_map.vh ----
// How it works
// - direction bit 1 enables the pin driver; 0 leaves the pin an input.
// - reset clears all direction bits of ports a, b and c.
// - port a read returns the latch where the direction bit is 1.
// - where the direction bit is 0, a data read returns the pin level.
// - port b data read picks latch or pin per bit by its direction.
// - port c data read picks latch or pin per bit by its direction.
// - data writes always update the latches whatever the direction.
// - a write to an input pin changes only the latch, not its readback.
// - each port a pullup enable bit connects its own pin pullup.
// - a pullup acts only while its pin is an input.
// - port b has six pins, latches and direction bits, shared with analog.
// - port c has two bidirectional pins with latch and direction bits.
// - reset leaves the port b and c data latches unchanged.
// - an analog channel select on a port b pin turns off its driver; its data read still follows its direction bit.
// - port a has four data latches behind the port a data register.
`ifndef PIO_MAP_VH
`define PIO_MAP_VH
`define PIO_ADDR_W 4
`define PIO_OFF_A_LATCH 4'h0
`define PIO_OFF_B_LATCH 4'h1
`define PIO_OFF_C_LATCH 4'h2
`define PIO_OFF_A_DIR 4'h4
`define PIO_OFF_B_DIR 4'h5
`define PIO_OFF_C_DIR 4'h6
`define PIO_OFF_A_PULLUP 4'h7
`define PIO_OFF_ANALOG_SEL 4'h8
`define PIO_A_W 4
`define PIO_B_W 6
`define PIO_C_W 2
`define PIO_BYTE_W 8
`define PIO_BE_LANE 0
`define PIO_A_DIR_RESET 4'h0
`define PIO_B_DIR_RESET 6'h00
`define PIO_C_DIR_RESET 2'h0
`define PIO_PULLUP_RESET 4'h0
`define PIO_SEL_RESET 6'h00
`define PIO_A_ZERO 4'h0
`define PIO_B_ZERO 6'h00
`define PIO_C_ZERO 2'h0
`define PIO_A_PAD 4'h0
`define PIO_B_PAD 2'h0
`define PIO_C_PAD 6'h00
`define PIO_BYTE_ZERO 8'h00
`define PIO_UPPER_ZERO 24'h00_0000
`define PIO_UNMAPPED_DATA 32'h0000_0000
`endif

// ---- pio_ports.v ----
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "pio_map.vh"
module pio_ports (
	input wire i_clk,
	input wire i_rst_n,
	input wire [`PIO_ADDR_W-1:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output reg [31:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	input wire [`PIO_A_W-1:0] i_port_a_pin,
	output reg [`PIO_A_W-1:0] o_port_a_pin,
	output reg [`PIO_A_W-1:0] o_port_a_oe,
	output reg [`PIO_A_W-1:0] o_port_a_pullup,
	input wire [`PIO_B_W-1:0] i_port_b_pin,
	output reg [`PIO_B_W-1:0] o_port_b_pin,
	output reg [`PIO_B_W-1:0] o_port_b_oe,
	output reg [`PIO_B_W-1:0] o_analog_channel_pins,
	input wire [`PIO_C_W-1:0] i_port_c_pin,
	output reg [`PIO_C_W-1:0] o_port_c_pin,
	output reg [`PIO_C_W-1:0] o_port_c_oe
);

// per bit: latch where the direction bit is 1, pin level where it is 0
function [`PIO_BYTE_W-1:0] pick;
	input [`PIO_BYTE_W-1:0] dir;
	input [`PIO_BYTE_W-1:0] latch;
	input [`PIO_BYTE_W-1:0] pin;
	begin
		pick = (dir & latch) | (~dir & pin);
	end
endfunction

// write strobe of one register
function hit;
	input [`PIO_ADDR_W-1:0] addr;
	input [`PIO_ADDR_W-1:0] target;
	input strobe;
	begin
		hit = strobe & (addr == target);
	end
endfunction

// latches have no reset, as the port data must survive a reset
reg [`PIO_A_W-1:0] port_a_latch_reg;
reg [`PIO_A_W-1:0] port_a_latch_next;
reg [`PIO_B_W-1:0] port_b_latch_reg;
reg [`PIO_B_W-1:0] port_b_latch_next;
reg [`PIO_C_W-1:0] port_c_latch_reg;
reg [`PIO_C_W-1:0] port_c_latch_next;
reg [`PIO_A_W-1:0] port_a_dir_reg;
reg [`PIO_A_W-1:0] port_a_dir_next;
reg [`PIO_B_W-1:0] port_b_dir_reg;
reg [`PIO_B_W-1:0] port_b_dir_next;
reg [`PIO_C_W-1:0] port_c_dir_reg;
reg [`PIO_C_W-1:0] port_c_dir_next;
reg [`PIO_A_W-1:0] port_a_pullup_en_reg;
reg [`PIO_A_W-1:0] port_a_pullup_en_next;
reg [`PIO_B_W-1:0] analog_sel_reg;
reg [`PIO_B_W-1:0] analog_sel_next;
reg ack_reg;
reg ack_next;
reg wait_next;
reg [`PIO_BYTE_W-1:0] read_byte;
reg [31:0] rdata_next;
// next values of the registered pins
reg [`PIO_A_W-1:0] a_oe_next;
reg [`PIO_B_W-1:0] b_oe_next;
reg [`PIO_C_W-1:0] c_oe_next;
reg [`PIO_A_W-1:0] a_pullup_next;
reg [`PIO_B_W-1:0] analog_pins_next;
reg [`PIO_A_W-1:0] a_pin_next;
reg [`PIO_B_W-1:0] b_pin_next;
reg [`PIO_C_W-1:0] c_pin_next;

// write strobes, one per register
wire req;
wire first;
wire wr_lo;
wire [`PIO_BYTE_W-1:0] wd;
wire [`PIO_B_W-1:0] b_dir_eff;
wire a_latch_we;
wire b_latch_we;
wire c_latch_we;
wire a_dir_we;
wire b_dir_we;
wire c_dir_we;
wire a_pullup_we;
wire analog_we;

// only the first cycle of a request acts; the answer cycle is ignored
assign req = i_avs_read | i_avs_write;
assign first = req & ~ack_reg;
assign wr_lo = i_avs_write & i_avs_byteenable[`PIO_BE_LANE] & ~ack_reg;
assign wd = i_avs_writedata[`PIO_BYTE_W-1:0];
// an analog pin is never driven, whatever its direction bit says
assign b_dir_eff = port_b_dir_reg & ~analog_sel_reg;
assign a_latch_we = hit(i_avs_address, `PIO_OFF_A_LATCH, wr_lo);
assign b_latch_we = hit(i_avs_address, `PIO_OFF_B_LATCH, wr_lo);
assign c_latch_we = hit(i_avs_address, `PIO_OFF_C_LATCH, wr_lo);
assign a_dir_we = hit(i_avs_address, `PIO_OFF_A_DIR, wr_lo);
assign b_dir_we = hit(i_avs_address, `PIO_OFF_B_DIR, wr_lo);
assign c_dir_we = hit(i_avs_address, `PIO_OFF_C_DIR, wr_lo);
assign a_pullup_we = hit(i_avs_address, `PIO_OFF_A_PULLUP, wr_lo);
assign analog_we = hit(i_avs_address, `PIO_OFF_ANALOG_SEL, wr_lo);

// one wait cycle: request seen, answer registered on the next edge
always @* begin
	ack_next = first;
	wait_next = ~first;
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n)
		ack_reg <= 1'b0;
	else
		ack_reg <= ack_next;
end

// waitrequest stays high while idle and in reset
always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n)
		o_avs_waitrequest <= 1'b1;
	else
		o_avs_waitrequest <= wait_next;
end

// unmapped addresses fall to the default and read zero
always @* begin
	read_byte = `PIO_BYTE_ZERO;
	case (i_avs_address)
	`PIO_OFF_A_LATCH: read_byte = pick({`PIO_A_PAD, port_a_dir_reg},
		{`PIO_A_PAD, port_a_latch_reg},
		{`PIO_A_PAD, i_port_a_pin});
	`PIO_OFF_B_LATCH: read_byte = pick({`PIO_B_PAD, port_b_dir_reg},
		{`PIO_B_PAD, port_b_latch_reg},
		{`PIO_B_PAD, i_port_b_pin});
	`PIO_OFF_C_LATCH: read_byte = pick({`PIO_C_PAD, port_c_dir_reg},
		{`PIO_C_PAD, port_c_latch_reg},
		{`PIO_C_PAD, i_port_c_pin});
	`PIO_OFF_A_DIR: read_byte = {`PIO_A_PAD, port_a_dir_reg};
	`PIO_OFF_B_DIR: read_byte = {`PIO_B_PAD, port_b_dir_reg};
	`PIO_OFF_C_DIR: read_byte = {`PIO_C_PAD, port_c_dir_reg};
	`PIO_OFF_A_PULLUP: read_byte = {`PIO_A_PAD, port_a_pullup_en_reg};
	`PIO_OFF_ANALOG_SEL: read_byte = {`PIO_B_PAD, analog_sel_reg};
	default: read_byte = `PIO_BYTE_ZERO;
	endcase
end

// read data hold until the next read, so a late master still finds them
always @* begin
	rdata_next = o_avs_readdata;
	if (i_avs_read & ~ack_reg)
		rdata_next = {`PIO_UPPER_ZERO, read_byte};
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n)
		o_avs_readdata <= `PIO_UNMAPPED_DATA;
	else
		o_avs_readdata <= rdata_next;
end

// data writes always land in the latch, whatever the direction bit says
always @* begin
	port_a_latch_next = port_a_latch_reg;
	if (a_latch_we) begin
		port_a_latch_next = wd[`PIO_A_W-1:0];
	end
end

always @(posedge i_clk) begin
	port_a_latch_reg <= port_a_latch_next;
end

always @* begin
	port_b_latch_next = port_b_latch_reg;
	if (b_latch_we) begin
		port_b_latch_next = wd[`PIO_B_W-1:0];
	end
end

always @(posedge i_clk) begin
	port_b_latch_reg <= port_b_latch_next;
end

always @* begin
	port_c_latch_next = port_c_latch_reg;
	if (c_latch_we) begin
		port_c_latch_next = wd[`PIO_C_W-1:0];
	end
end

always @(posedge i_clk) begin
	port_c_latch_reg <= port_c_latch_next;
end

// upper write bits are cut off, so unused bits stay zero
always @* begin
	port_a_dir_next = port_a_dir_reg;
	if (a_dir_we) begin
		port_a_dir_next = wd[`PIO_A_W-1:0];
	end
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		port_a_dir_reg <= `PIO_A_DIR_RESET;
	end else begin
		port_a_dir_reg <= port_a_dir_next;
	end
end

always @* begin
	port_b_dir_next = port_b_dir_reg;
	if (b_dir_we) begin
		port_b_dir_next = wd[`PIO_B_W-1:0];
	end
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		port_b_dir_reg <= `PIO_B_DIR_RESET;
	end else begin
		port_b_dir_reg <= port_b_dir_next;
	end
end

always @* begin
	port_c_dir_next = port_c_dir_reg;
	if (c_dir_we) begin
		port_c_dir_next = wd[`PIO_C_W-1:0];
	end
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		port_c_dir_reg <= `PIO_C_DIR_RESET;
	end else begin
		port_c_dir_reg <= port_c_dir_next;
	end
end

// each pin has its own enable bit
always @* begin
	port_a_pullup_en_next = port_a_pullup_en_reg;
	if (a_pullup_we) begin
		port_a_pullup_en_next = wd[`PIO_A_W-1:0];
	end
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		port_a_pullup_en_reg <= `PIO_PULLUP_RESET;
	end else begin
		port_a_pullup_en_reg <= port_a_pullup_en_next;
	end
end

// several pins may be handed over at once; the converter picks among them
always @* begin
	analog_sel_next = analog_sel_reg;
	if (analog_we) begin
		analog_sel_next = wd[`PIO_B_W-1:0];
	end
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		analog_sel_reg <= `PIO_SEL_RESET;
	end else begin
		analog_sel_reg <= analog_sel_next;
	end
end

// pin drive is registered, so it lags a register write by one cycle
always @* begin
	a_oe_next = port_a_dir_reg;
	a_pullup_next = port_a_pullup_en_reg & ~port_a_dir_reg;
	a_pin_next = port_a_latch_reg;
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_port_a_oe <= `PIO_A_ZERO;
		o_port_a_pullup <= `PIO_A_ZERO;
		o_port_a_pin <= `PIO_A_ZERO;
	end else begin
		o_port_a_oe <= a_oe_next;
		o_port_a_pullup <= a_pullup_next;
		o_port_a_pin <= a_pin_next;
	end
end

// an analog pin is left undriven; its latch is kept for later
always @* begin
	b_oe_next = b_dir_eff;
	analog_pins_next = analog_sel_reg;
	b_pin_next = port_b_latch_reg;
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_port_b_oe <= `PIO_B_ZERO;
		o_analog_channel_pins <= `PIO_B_ZERO;
		o_port_b_pin <= `PIO_B_ZERO;
	end else begin
		o_port_b_oe <= b_oe_next;
		o_analog_channel_pins <= analog_pins_next;
		o_port_b_pin <= b_pin_next;
	end
end

// port c has no pullups, so only drive and level
always @* begin
	c_oe_next = port_c_dir_reg;
	c_pin_next = port_c_latch_reg;
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_port_c_oe <= `PIO_C_ZERO;
		o_port_c_pin <= `PIO_C_ZERO;
	end else begin
		o_port_c_oe <= c_oe_next;
		o_port_c_pin <= c_pin_next;
	end
end

endmodule
`default_nettype wire

// ---- pio_ports_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module pio_ports_chk (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] o_avs_readdata,
	input wire o_avs_waitrequest,
	input wire [3:0] o_port_a_oe,
	input wire [3:0] o_port_a_pullup,
	input wire [5:0] o_port_b_oe,
	input wire [5:0] o_analog_channel_pins,
	input wire [1:0] o_port_c_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_pull_input: assert property (!(o_port_a_pullup & o_port_a_oe))
		else $error("pullup on driven pin");
	a_analog_owns: assert property (!(o_analog_channel_pins & o_port_b_oe))
		else $error("analog pin driven");
	a_reset_inputs: assert property ($rose(i_rst_n) |->
		!{o_port_a_oe, o_port_b_oe, o_port_c_oe}) else $error("pin driven");
	a_dir_cause: assert property ($changed({o_port_a_oe, o_port_a_pullup})
		|-> $past(i_avs_write) || $past(i_avs_write, 2)) else $error("oe moved");
	a_upper_zero: assert property (!o_avs_waitrequest |->
		o_avs_readdata[31:8] == 24'h0) else $error("upper bits set");
	a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("wait low too long");
	a_wait_idle: assert property (!(i_avs_read || i_avs_write) |=>
		o_avs_waitrequest) else $error("ack without request");
	a_wait_bound: assert property ((i_avs_read || i_avs_write) &&
		o_avs_waitrequest |-> ##[1:2] !o_avs_waitrequest) else $error("no ack");
	cover property ($rose(|o_port_a_pullup));
	cover property (|o_analog_channel_pins);
	cover property (i_avs_write && !o_avs_waitrequest);
endmodule
bind pio_ports pio_ports_chk u_chk (.*);
`default_nettype wire

// ---- pio_board.sv ----
`timescale 1ns/100ps
`default_nettype none
module pio_board #(parameter int W = 4) (
	input wire logic [W-1:0] i_oe,
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_pu,
	input wire logic [W-1:0] i_rel,
	input wire logic [W-1:0] i_ext,
	input wire logic i_t,
	output logic [W-1:0] o_lvl
);
	// a released pin without pullup wanders, so it can never read as stale
	assign o_lvl = i_oe & i_out | ~i_oe & (i_rel & (i_pu | {W{i_t}}) | ~i_rel & i_ext);
endmodule
`default_nettype wire

// ---- pio_ports_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module pio_ports_test;
	logic i_clk = 1'h0, i_rst_n = 1'h0, i_avs_read = 1'h0, i_avs_write = 1'h0;
	logic [3:0] i_avs_address = '0, i_avs_byteenable = 4'hf, ea = '0, ra = '0;
	logic [31:0] i_avs_writedata = '0, o_avs_readdata;
	logic o_avs_waitrequest;
	logic [3:0] i_port_a_pin, o_port_a_pin, o_port_a_oe, o_port_a_pullup;
	logic [5:0] i_port_b_pin, o_port_b_pin, o_port_b_oe, o_analog_channel_pins;
	logic [5:0] eb = '0;
	logic [1:0] i_port_c_pin, o_port_c_pin, o_port_c_oe, ec = '0;
	logic [15:0] lf = 16'hdbb5;
	logic [7:0] d, v, p, s;
	int n_fail = 0, n_tests = 0;
	pio_ports i_dut (.*);
	pio_board #(4) u_a (.i_oe(o_port_a_oe), .i_out(o_port_a_pin), .i_pu(o_port_a_pullup),
		.i_rel(ra), .i_ext(ea), .i_t(i_clk), .o_lvl(i_port_a_pin));
	pio_board #(6) u_b (.i_oe(o_port_b_oe), .i_out(o_port_b_pin), .i_pu(6'h0),
		.i_rel(6'h0), .i_ext(eb), .i_t(i_clk), .o_lvl(i_port_b_pin));
	pio_board #(2) u_c (.i_oe(o_port_c_oe), .i_out(o_port_c_pin), .i_pu(2'h0),
		.i_rel(2'h0), .i_ext(ec), .i_t(i_clk), .o_lvl(i_port_c_pin));
	always #2.5 i_clk = ~i_clk;
	function logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function logic [7:0] m(input logic [7:0] l, dv, pin, w);
		return (l & dv | pin & ~dv) & w;
	endfunction
	task conclude;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task cmp(input string n, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task rw(input logic w, input logic [3:0] a, input logic [7:0] wd, e);
		int k;
		k = 0;
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= {24'h0, wd};
		i_avs_write <= w;
		i_avs_read <= !w;
		do @(posedge i_clk); while (o_avs_waitrequest !== 1'h0 && ++k < 9);
		if (k == 9) begin
			n_fail++;
			conclude;
		end
		if (!w) cmp("readdata", e, o_avs_readdata[7:0]);
		i_avs_read <= 1'h0;
		i_avs_write <= 1'h0;
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'h1;
		for (int a = 4; a < 8; a++) rw(0, a, 8'h0, 8'h0);
		rw(1, 5, 8'hff, 8'h0);
		rw(0, 5, 8'h0, 8'h3f);
		rw(0, 4'hf, 8'h0, 8'h0);
		i_avs_byteenable <= 4'he;
		rw(1, 4, 8'h0f, 8'h0);
		i_avs_byteenable <= 4'hf;
		rw(0, 4, 8'h0, 8'h0);
		for (int n = 0; n < 8; n++) begin
			lf = nx(lf); {d, v} = lf;
			lf = nx(lf); {p, s} = lf;
			lf = nx(lf);
			v = n == 0 ? 8'hff : n == 1 ? 8'h0 : v;
			ea <= lf[3:0]; eb <= lf[9:4]; ec <= lf[11:10]; ra <= p[3:0];
			for (int k = 0; k < 3; k++) rw(1, k[3:0], d, 8'h0);
			for (int k = 4; k < 7; k++) rw(1, k[3:0], v, 8'h0);
			rw(1, 7, p, 8'h0);
			rw(1, 8, s, 8'h0);
			rw(0, 0, 8'h0, m(d, v, {4'h0, ea | p[3:0]}, 8'h0f));
			rw(0, 1, 8'h0, m(d, v, {2'h0, eb}, 8'h3f));
			rw(0, 2, 8'h0, m(d, v, {6'h0, ec}, 8'h03));
			rw(0, 7, 8'h0, p & 8'h0f);
			rw(0, 8, 8'h0, s & 8'h3f);
			cmp("b_oe", v & ~s & 8'h3f, {2'h0, o_port_b_oe});
			cmp("a_pullup", p & ~v & 8'h0f, {4'h0, o_port_a_pullup});
			cmp("a_oe", v & 8'h0f, {4'h0, o_port_a_oe});
			cmp("c_oe", v & 8'h03, {6'h0, o_port_c_oe});
			cmp("analog", s & 8'h3f, {2'h0, o_analog_channel_pins});
			cmp("a_pin", d & 8'h0f, {4'h0, o_port_a_pin});
			cmp("b_pin", d & 8'h3f, {2'h0, o_port_b_pin});
			cmp("c_pin", d & 8'h03, {6'h0, o_port_c_pin});
			$display("test %0d done", n);
		end
		i_rst_n <= 1'h0;
		@(posedge i_clk);
		i_rst_n <= 1'h1;
		for (int a = 4; a < 9; a++) rw(0, a, 8'h0, 8'h0);
		rw(1, 5, 8'h30, 8'h0);
		rw(1, 6, 8'hff, 8'h0);
		rw(0, 1, 8'h0, m(d, 8'h30, {2'h0, eb}, 8'h3f));
		rw(0, 2, 8'h0, d & 8'h03);
		$display("test reset done");
		conclude;
	end
endmodule
`default_nettype wire
